// *** common/cpu_regs_consts.svh ***
// constants of the cpu register set: offsets, fields, reset values, vectors, timing
// What this block does
// - sixteen-bit index pair from two bytes
// - reset loads stack pointer with 00ff
// - stack reset instruction sets low byte ff
// - push decrements, pull increments stack pointer
// - program counter steps unless jump, branch, interrupt
// - reset fetches program counter from fffe/ffff
// - flag bits six and five always one
// - overflow flag tracks two's complement overflow
// - half carry from bit three on adds
// - mask bit three blocks maskable interrupts
// - stack registers, then set mask, then vector
// - index high byte never stacked on entry
// - highest priority pending request served first
// - return instruction restores registers and mask
// - reset sets mask; clear, wait and stop instructions clear it; flag loads and port writes load it
// - negative flag copies result bit seven
// - zero flag set on zero result
// - carry from add, borrow, shifts, bit tests
// - wait clears mask, stops clock, wakes
// - stop clears mask; clock waits for stabilization
// - break loads opcode and break vector
// - break starts only at instruction end
`ifndef CPU_REGS_CONSTS_SVH
`define CPU_REGS_CONSTS_SVH

// ==========================================================
// flag register layout
`define CCR_V 7
`define CCR_H 4
`define CCR_I 3
`define CCR_N 2
`define CCR_Z 1
`define CCR_C 0
`define CCR_ONES 8'h60
`define CCR_RST 8'h68

// ==========================================================
// reset values and vectors
`define SP_RST 16'h00ff
`define SP_LO_RSP 8'hff
`define VEC_RESET 16'hfffe
`define VEC_BREAK 16'hfffc
`define VEC_BREAK_MON 16'hfefc
`define VEC_IRQ_TOP 16'hfffa
`define PUSH_LAST 3'h4
`define SWI_OPCODE_DEF 8'h00

// ==========================================================
// timing: oscillator stabilization in clock cycles
`define STAB_CYCLES 4096

// ==========================================================
// register port offsets
`define OFF_ACC 4'h0
`define OFF_IDX_HI 4'h1
`define OFF_IDX_LO 4'h2
`define OFF_SP_HI 4'h3
`define OFF_SP_LO 4'h4
`define OFF_PC_HI 4'h5
`define OFF_PC_LO 4'h6
`define OFF_CCR 4'h7
`define OFF_STATE 4'h8
`define OFF_IR 4'h9

`endif

// *** common/cpu_regs_pkg.sv ***
// types of the cpu register set
package cpu_regs_pkg;

	// ==========================================================
	// sequencer operations
	typedef enum logic [4:0] {
		OP_NONE = 5'h00,
		OP_ADD = 5'h01,
		OP_ADC = 5'h02,
		OP_SUB = 5'h03,
		OP_SBC = 5'h04,
		OP_AND = 5'h05,
		OP_ORA = 5'h06,
		OP_EOR = 5'h07,
		OP_LDA = 5'h08,
		OP_ASL = 5'h09,
		OP_LSR = 5'h0a,
		OP_ROL = 5'h0b,
		OP_ROR = 5'h0c,
		OP_FETCH = 5'h0d,
		OP_JUMP = 5'h0e,
		OP_LDHX = 5'h0f,
		OP_LDSP = 5'h10,
		OP_PUSH = 5'h11,
		OP_PULL = 5'h12,
		OP_RSP = 5'h13,
		OP_CLI = 5'h14,
		OP_SEI = 5'h15,
		OP_TAP = 5'h16,
		OP_BITC = 5'h17,
		OP_SWI = 5'h18,
		OP_RTI = 5'h19,
		OP_WAIT = 5'h1a,
		OP_STOP = 5'h1b
	} op_t;

	typedef enum logic [7:0] {
		ST_RUN = 8'h01,
		ST_PUSH = 8'h02,
		ST_VEC = 8'h04,
		ST_PULL = 8'h08,
		ST_WAIT = 8'h10,
		ST_STOP = 8'h20,
		ST_STAB = 8'h40
	} fsm_t;

	typedef struct packed {
		op_t op;
		logic [7:0] operand;
		logic [15:0] target;
	} seq_cmd_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} mem_req_t;

	typedef struct packed {
		logic [7:0] acc;
		logic [15:0] idx;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [7:0] condition_flags;
	} cpu_view_t;

	typedef struct packed {
		logic [7:0] res;
		logic [7:0] f;
	} alu_t;

	typedef struct packed {
		fsm_t fsm;
		logic [7:0] acc;
		logic [15:0] idx;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [7:0] condition_flags;
		logic [7:0] ir;
		logic [15:0] vec;
		logic [2:0] cnt;
		logic [1:0] ph;
		logic [15:0] stab;
		logic brk;
		mem_req_t mem;
		logic [7:0] rdata;
	} st_t;

endpackage

// *** core/cpu_register_set_and_flags.sv ***
// programmer-visible cpu registers, flags, interrupt entry/return, low power and break
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`include "cpu_regs_consts.svh"

module cpu_register_set_and_flags import cpu_regs_pkg::*; #(
	parameter int IRQ_N = 4,
	parameter int STAB_CYCLES = `STAB_CYCLES,
	parameter logic [7:0] SWI_OPCODE = `SWI_OPCODE_DEF
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire seq_cmd_t seq_cmd,
	input wire logic instr_done,
	output logic seq_ready,
	input wire logic [IRQ_N-1:0] irq_req,
	input wire logic break_req,
	input wire logic monitor_mode,
	input wire logic [7:0] mem_rdata,
	output mem_req_t mem,
	output cpu_view_t view,
	output logic [7:0] instr_reg,
	output logic cpu_clk_run
);

	// ==========================================================
	// parameter checks
	if (IRQ_N < 1 || IRQ_N > 8) begin : g_bad_irq
		$error("IRQ_N must be 1 to 8");
	end
	if (STAB_CYCLES < 1 || STAB_CYCLES > 65535) begin : g_bad_stab
		$error("STAB_CYCLES must be 1 to 65535");
	end

	localparam st_t ST_RESET = '{
		fsm: ST_VEC,
		sp: `SP_RST,
		condition_flags: `CCR_RST,
		vec: `VEC_RESET,
		default: '0
	};

	// ==========================================================
	// helpers
	function automatic logic [7:0] fix_ccr(input logic [7:0] f);
		fix_ccr = f | `CCR_ONES;
	endfunction

	// lowest index wins: it is the highest priority source
	function automatic logic [15:0] irq_vec(input logic [IRQ_N-1:0] req);
		logic [15:0] v;
		v = `VEC_IRQ_TOP;
		for (int i = IRQ_N - 1; i >= 0; i--) begin
			if (req[i]) begin
				v = `VEC_IRQ_TOP - 16'({i[14:0], 1'b0});
			end
		end
		irq_vec = v;
	endfunction

	// stacking order: pc low, pc high, index low, accumulator, flags
	function automatic logic [7:0] push_byte(input st_t s);
		unique case (s.cnt)
			3'h0: push_byte = s.pc[7:0];
			3'h1: push_byte = s.pc[15:8];
			3'h2: push_byte = s.idx[7:0];
			3'h3: push_byte = s.acc;
			default: push_byte = s.condition_flags;
		endcase
	endfunction

	function automatic alu_t alu(input op_t op, input logic [7:0] a, input logic [7:0] m,
			input logic [7:0] f);
		alu_t r;
		logic [8:0] s9;
		logic [4:0] s5;
		logic cin;
		logic nz;
		r.res = a;
		r.f = f;
		s9 = '0;
		s5 = '0;
		cin = (op == OP_ADC || op == OP_SBC) ? f[`CCR_C] : 1'b0;
		nz = 1'b1;
		case (op)
			OP_ADD, OP_ADC: begin
				s9 = {1'b0, a} + {1'b0, m} + {8'h00, cin};
				s5 = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
				r.res = s9[7:0];
				r.f[`CCR_C] = s9[8];
				r.f[`CCR_H] = s5[4];
				r.f[`CCR_V] = (a[7] == m[7]) && (s9[7] != a[7]);
			end
			OP_SUB, OP_SBC: begin
				s9 = {1'b0, a} - {1'b0, m} - {8'h00, cin};
				r.res = s9[7:0];
				r.f[`CCR_C] = s9[8];
				r.f[`CCR_V] = (a[7] != m[7]) && (s9[7] != a[7]);
			end
			OP_AND: begin
				r.res = a & m;
				r.f[`CCR_V] = 1'b0;
			end
			OP_ORA: begin
				r.res = a | m;
				r.f[`CCR_V] = 1'b0;
			end
			OP_EOR: begin
				r.res = a ^ m;
				r.f[`CCR_V] = 1'b0;
			end
			OP_LDA: begin
				r.res = m;
				r.f[`CCR_V] = 1'b0;
			end
			OP_ASL, OP_ROL: begin
				r.res = {a[6:0], (op == OP_ROL) ? f[`CCR_C] : 1'b0};
				r.f[`CCR_C] = a[7];
				r.f[`CCR_V] = a[7] ^ a[6];
			end
			OP_LSR, OP_ROR: begin
				r.res = {(op == OP_ROR) ? f[`CCR_C] : 1'b0, a[7:1]};
				r.f[`CCR_C] = a[0];
				r.f[`CCR_V] = r.res[7] ^ a[0];
			end
			default: begin
				nz = 1'b0;
			end
		endcase
		if (nz) begin
			r.f[`CCR_N] = r.res[7];
			r.f[`CCR_Z] = (r.res == 8'h00);
		end
		alu = r;
	endfunction

	// ==========================================================
	// state
	st_t s_r;
	st_t s_nxt;
	alu_t alu_out;
	logic go_int;
	logic go_brk;
	logic [15:0] go_vec;

	always_comb begin
		s_nxt = s_r;
		alu_out = alu(seq_cmd.op, s_r.acc, seq_cmd.operand, s_r.condition_flags);
		go_int = 1'b0;
		go_brk = 1'b0;
		go_vec = irq_vec(irq_req);
		s_nxt.mem = '0;
		s_nxt.rdata = 8'h00;
		// a break request is held until the instruction boundary; serving it clears it
		s_nxt.brk = s_r.brk | break_req;
		unique case (s_r.fsm)
			ST_RUN: begin
				s_nxt.acc = alu_out.res;
				s_nxt.condition_flags = fix_ccr(alu_out.f);
				case (seq_cmd.op)
					OP_FETCH: begin
						s_nxt.pc = s_r.pc + 16'h0001;
					end
					OP_JUMP: begin
						s_nxt.pc = seq_cmd.target;
					end
					OP_LDHX: begin
						s_nxt.idx = seq_cmd.target;
					end
					OP_LDSP: begin
						s_nxt.sp = seq_cmd.target;
					end
					OP_PUSH: begin
						s_nxt.mem.wr = 1'b1;
						s_nxt.mem.addr = s_r.sp;
						s_nxt.mem.wdata = seq_cmd.operand;
						s_nxt.sp = s_r.sp - 16'h0001;
					end
					OP_PULL: begin
						s_nxt.sp = s_r.sp + 16'h0001;
					end
					OP_RSP: begin
						s_nxt.sp[7:0] = `SP_LO_RSP;
					end
					OP_CLI: begin
						s_nxt.condition_flags[`CCR_I] = 1'b0;
					end
					OP_SEI: begin
						s_nxt.condition_flags[`CCR_I] = 1'b1;
					end
					OP_TAP: begin
						s_nxt.condition_flags = fix_ccr(seq_cmd.operand);
					end
					OP_BITC: begin
						s_nxt.condition_flags[`CCR_C] = seq_cmd.operand[0];
					end
					OP_SWI: begin
						go_int = 1'b1;
						go_vec = `VEC_BREAK;
					end
					OP_RTI: begin
						s_nxt.fsm = ST_PULL;
						s_nxt.cnt = 3'h0;
						s_nxt.ph = 2'h0;
					end
					OP_WAIT: begin
						s_nxt.condition_flags[`CCR_I] = 1'b0;
						s_nxt.fsm = ST_WAIT;
					end
					OP_STOP: begin
						s_nxt.condition_flags[`CCR_I] = 1'b0;
						s_nxt.fsm = ST_STOP;
					end
					default: ;
				endcase
				if (instr_done && (break_req || s_r.brk)) begin
					go_int = 1'b1;
					go_brk = 1'b1;
					s_nxt.ir = SWI_OPCODE;
					go_vec = monitor_mode ? `VEC_BREAK_MON : `VEC_BREAK;
				end else if (instr_done && (|irq_req) && !s_r.condition_flags[`CCR_I]) begin
					go_int = 1'b1;
				end
			end
			ST_PUSH: begin
				s_nxt.mem.wr = 1'b1;
				s_nxt.mem.addr = s_r.sp;
				s_nxt.mem.wdata = push_byte(s_r);
				s_nxt.sp = s_r.sp - 16'h0001;
				s_nxt.cnt = s_r.cnt + 3'h1;
				if (s_r.cnt == `PUSH_LAST) begin
					// mask goes up only after the flags were stacked
					s_nxt.condition_flags[`CCR_I] = 1'b1;
					s_nxt.fsm = ST_VEC;
					s_nxt.cnt = 3'h0;
				end
			end
			ST_VEC: begin
				s_nxt.cnt = s_r.cnt + 3'h1;
				unique case (s_r.cnt)
					3'h0: begin
						s_nxt.mem.rd = 1'b1;
						s_nxt.mem.addr = s_r.vec;
					end
					3'h2: begin
						s_nxt.pc[15:8] = mem_rdata;
						s_nxt.mem.rd = 1'b1;
						s_nxt.mem.addr = s_r.vec + 16'h0001;
					end
					3'h4: begin
						s_nxt.pc[7:0] = mem_rdata;
						s_nxt.fsm = ST_RUN;
						s_nxt.cnt = 3'h0;
					end
					default: ;
				endcase
			end
			ST_PULL: begin
				s_nxt.ph = s_r.ph + 2'h1;
				if (s_r.ph == 2'h0) begin
					s_nxt.mem.rd = 1'b1;
					s_nxt.mem.addr = s_r.sp + 16'h0001;
					s_nxt.sp = s_r.sp + 16'h0001;
				end else if (s_r.ph == 2'h2) begin
					s_nxt.ph = 2'h0;
					s_nxt.cnt = s_r.cnt + 3'h1;
					unique case (s_r.cnt)
						3'h0: begin
							s_nxt.condition_flags = fix_ccr(mem_rdata);
						end
						3'h1: begin
							s_nxt.acc = mem_rdata;
						end
						3'h2: begin
							s_nxt.idx[7:0] = mem_rdata;
						end
						3'h3: begin
							s_nxt.pc[15:8] = mem_rdata;
						end
						default: begin
							s_nxt.pc[7:0] = mem_rdata;
							s_nxt.fsm = ST_RUN;
							s_nxt.cnt = 3'h0;
						end
					endcase
				end
			end
			ST_WAIT: begin
				// any request wakes the core; the entry sets the mask after stacking
				if (|irq_req) begin
					go_int = 1'b1;
				end
			end
			ST_STOP: begin
				if (|irq_req) begin
					s_nxt.fsm = ST_STAB;
					s_nxt.stab = 16'h0000;
				end
			end
			ST_STAB: begin
				s_nxt.stab = s_r.stab + 16'h0001;
				// a request that went away meanwhile still enters, through the top vector fffa
				if (s_r.stab == 16'(STAB_CYCLES - 1)) begin
					go_int = 1'b1;
				end
			end
		endcase
		if (go_int) begin
			s_nxt.fsm = ST_PUSH;
			s_nxt.cnt = 3'h0;
			s_nxt.vec = go_vec;
			// only the break being served is consumed; one latched beside
			// another entry must survive it
			if (go_brk) begin
				s_nxt.brk = 1'b0;
			end
		end
		// debug port writes take precedence over the sequencer
		if (reg_wr) begin
			unique case (reg_addr)
				`OFF_ACC: s_nxt.acc = reg_wdata;
				`OFF_IDX_HI: s_nxt.idx[15:8] = reg_wdata;
				`OFF_IDX_LO: s_nxt.idx[7:0] = reg_wdata;
				`OFF_SP_HI: s_nxt.sp[15:8] = reg_wdata;
				`OFF_SP_LO: s_nxt.sp[7:0] = reg_wdata;
				`OFF_PC_HI: s_nxt.pc[15:8] = reg_wdata;
				`OFF_PC_LO: s_nxt.pc[7:0] = reg_wdata;
				`OFF_CCR: s_nxt.condition_flags = fix_ccr(reg_wdata);
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`OFF_ACC: s_nxt.rdata = s_r.acc;
				`OFF_IDX_HI: s_nxt.rdata = s_r.idx[15:8];
				`OFF_IDX_LO: s_nxt.rdata = s_r.idx[7:0];
				`OFF_SP_HI: s_nxt.rdata = s_r.sp[15:8];
				`OFF_SP_LO: s_nxt.rdata = s_r.sp[7:0];
				`OFF_PC_HI: s_nxt.rdata = s_r.pc[15:8];
				`OFF_PC_LO: s_nxt.rdata = s_r.pc[7:0];
				`OFF_CCR: s_nxt.rdata = s_r.condition_flags;
				`OFF_STATE: s_nxt.rdata = s_r.fsm;
				`OFF_IR: s_nxt.rdata = s_r.ir;
				default: s_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= ST_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata = s_r.rdata;
	assign mem = s_r.mem;
	assign instr_reg = s_r.ir;
	assign view = '{
		acc: s_r.acc,
		idx: s_r.idx,
		sp: s_r.sp,
		pc: s_r.pc,
		condition_flags: s_r.condition_flags
	};
	assign seq_ready = (s_r.fsm == ST_RUN);
	// the clock generator gates the core clock from this level
	assign cpu_clk_run = !(s_r.fsm inside {ST_WAIT, ST_STOP, ST_STAB});

endmodule

// *** tb/cpu_regs_asserts.sv ***
// assertion checker for the cpu register set
module cpu_regs_asserts import cpu_regs_pkg::*; #(
	parameter int IRQ_N = 4
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic reg_wr,
	input wire seq_cmd_t seq_cmd,
	input wire logic instr_done,
	input wire logic seq_ready,
	input wire logic [IRQ_N-1:0] irq_req,
	input wire logic break_req,
	input wire mem_req_t mem,
	input wire cpu_view_t view
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====
	// helpers
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	logic go;
	// a port write to the same register wins, so ops beside one are skipped
	assign go = seq_ready && !reg_wr;
	sequence pushes;
		(mem.wr && !mem.rd) [*5];
	endsequence
	sequence vec_rd;
		mem.rd && mem.addr == 16'hfff8 && view.condition_flags[3];
	endsequence
	// =====
	// properties
	ones_bits_a: assert property (view.condition_flags[6:5] == 2'b11)
		else $error("flag bits 6 and 5 not one");
	reset_vals_a: assert property ($rose(arst_n) |->
		view.sp == 16'h00ff && view.condition_flags == 8'h68)
		else $error("wrong values after reset");
	rsp_low_a: assert property (go && seq_cmd.op == OP_RSP |=>
		view.sp[7:0] == 8'hff && view.sp[15:8] == $past(view.sp[15:8]))
		else $error("stack reset wrong");
	push_dec_a: assert property (go && seq_cmd.op == OP_PUSH |=>
		view.sp == $past(view.sp) - 16'h0001 && mem.wr && mem.addr == $past(view.sp))
		else $error("push wrong");
	pull_inc_a: assert property (go && seq_cmd.op == OP_PULL |=>
		view.sp == $past(view.sp) + 16'h0001)
		else $error("pull wrong");
	fetch_step_a: assert property (go && seq_cmd.op == OP_FETCH |=>
		view.pc == $past(view.pc) + 16'h0001)
		else $error("fetch did not step");
	alu_nz_a: assert property (go && seq_cmd.op inside {[OP_ADD:OP_ROR]} |=>
		view.condition_flags[2] == view.acc[7] && view.condition_flags[1] == (view.acc == 8'h00))
		else $error("n or z flag wrong");
	cli_clear_a: assert property (go && seq_cmd.op == OP_CLI |=> !view.condition_flags[3])
		else $error("mask not cleared");
	sleep_mask_a: assert property (go && seq_cmd.op inside {OP_WAIT, OP_STOP} |=> !view.condition_flags[3])
		else $error("sleep kept mask");
	// the first stacked byte shows one cycle after the push state is entered
	irq_entry_a: assert property (go && instr_done && !break_req && !view.condition_flags[3] &&
		irq_req[1:0] == 2'b10 |=> ##1 pushes ##1 vec_rd)
		else $error("entry order wrong");
endmodule

bind cpu_register_set_and_flags cpu_regs_asserts #(.IRQ_N(IRQ_N)) i_chk (
	.clock, .arst_n, .reg_wr, .seq_cmd, .instr_done,
	.seq_ready, .irq_req, .break_req, .mem, .view
);

// *** tb/cpu_register_set_and_flags_tb.sv ***
// self-checking testbench for the cpu register set
module cpu_register_set_and_flags_tb import cpu_regs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STAB = 4;
	localparam logic [7:0] SOFTWARE_INTERRUPT_INSTR = 8'h83; // arbitrary opcode
	logic clock, arst_n, reg_wr, reg_rd, instr_done, seq_ready;
	logic break_req, monitor_mode, cpu_clk_run;
	logic [3:0] reg_addr, irq_req;
	logic [7:0] reg_wdata, reg_rdata, mem_rdata, instr_reg, d;
	seq_cmd_t seq_cmd;
	mem_req_t mem;
	cpu_view_t view;
	logic [7:0] ram [0:255];
	int n_fail = 0;
	int tests_run = 0;
	cpu_register_set_and_flags #(.IRQ_N(4), .STAB_CYCLES(STAB), .SWI_OPCODE(SOFTWARE_INTERRUPT_INSTR))
		i_cpu_register_set_and_flags (
		.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.seq_cmd, .instr_done, .seq_ready, .irq_req, .break_req, .monitor_mode,
		.mem_rdata, .mem, .view, .instr_reg, .cpu_clk_run
	);
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// page zero is stack ram; elsewhere the byte is a mix of the address,
	// so every vector gives a distinct program counter
	always @(posedge clock) begin
		if (mem.wr)
			ram[mem.addr[7:0]] <= mem.wdata;
		mem_rdata <= mem.addr[15:8] == 8'h00 ? ram[mem.addr[7:0]] : mem.addr[15:8] ^ mem.addr[7:0];
	end
	// =====
	// shared tasks
	task automatic ck(input logic [15:0] g, e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		v = reg_rdata;
	endtask
	task automatic op(input op_t o, input logic [7:0] m, input logic [15:0] t);
		seq_cmd <= '{o, m, t};
		@(posedge clock);
		seq_cmd.op <= OP_NONE;
		@(posedge clock);
	endtask
	// bounded wait for the sequencer to come back
	task automatic wt;
		repeat (2) @(posedge clock);
		repeat (60) if (seq_ready !== 1'b1) @(posedge clock);
		ck(seq_ready, 1'b1);
	endtask
	task automatic alu(input op_t o, input logic [7:0] a, m, r, f);
		wr(4'h0, a);
		op(o, m, 16'h0000);
		ck(view.acc, r);
		ck(view.condition_flags & 8'h97, f);
	endtask
	task automatic give_verdict;
		if (n_fail == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// =====
	// scenarios
	task automatic t_reset;
		wt();
		ck(view.sp, 16'h00ff);
		ck(view.pc, 16'h0100);
		rd(4'h7, d);
		ck(d, 8'h68);
		rd(4'hf, d);
		ck(d, 8'h00);
	endtask
	task automatic t_regs;
		wr(4'h1, 8'hab);
		wr(4'h2, 8'hcd);
		ck(view.idx, 16'habcd);
		wr(4'h7, 8'h09);
		rd(4'h7, d);
		ck(d, 8'h69);
		wr(4'h3, 8'h12);
		wr(4'h4, 8'h34);
		op(OP_RSP, 8'h00, 16'h0000);
		ck(view.sp, 16'h12ff);
		wr(4'h3, 8'h00);
	endtask
	task automatic t_stack;
		op(OP_PUSH, 8'h5a, 16'h0000);
		ck(view.sp, 16'h00fe);
		op(OP_PULL, 8'h00, 16'h0000);
		ck(view.sp, 16'h00ff);
		ck(ram[8'hff], 8'h5a);
		op(OP_JUMP, 8'h00, 16'h1234);
		ck(view.pc, 16'h1234);
		op(OP_FETCH, 8'h00, 16'h0000);
		ck(view.pc, 16'h1235);
		op(OP_LDHX, 8'h00, 16'h55cd);
		ck(view.idx, 16'h55cd);
	endtask
	task automatic t_alu;
		alu(OP_ADD, 8'h7f, 8'h01, 8'h80, 8'h94);
		alu(OP_ADD, 8'hff, 8'h01, 8'h00, 8'h13);
		alu(OP_SUB, 8'h00, 8'h01, 8'hff, 8'h15);
		alu(OP_ADC, 8'h08, 8'h07, 8'h10, 8'h10);
		alu(OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h12);
		alu(OP_ROL, 8'h81, 8'h00, 8'h02, 8'h91);
		alu(OP_ROR, 8'h01, 8'h00, 8'h80, 8'h15);
		alu(OP_SBC, 8'h10, 8'h05, 8'h0a, 8'h10);
		op(OP_TAP, 8'h09, 16'h0000);
		ck(view.condition_flags, 16'h0069);
		op(OP_BITC, 8'h00, 16'h0000);
		ck(view.condition_flags, 16'h0068);
		op(OP_TAP, 8'h18, 16'h0000);
	endtask
	task automatic t_irq;
		wr(4'h0, 8'h3c);
		op(OP_JUMP, 8'h00, 16'h2468);
		irq_req <= 4'b0110;
		repeat (4) @(posedge clock);
		ck(seq_ready, 1'b1);
		op(OP_CLI, 8'h00, 16'h0000);
		wt();
		irq_req <= 4'b0000;
		ck(view.pc, 16'h0706);
		ck(view.condition_flags[3], 1'b1);
		ck(view.sp, 16'h00fa);
		ck({ram[8'hff], ram[8'hfe]}, 16'h6824);
		ck({ram[8'hfd], ram[8'hfc]}, 16'hcd3c);
		ck(ram[8'hfb], 8'h70);
		op(OP_RTI, 8'h00, 16'h0000);
		wt();
		ck(view.pc, 16'h2468);
		ck(view.condition_flags, 8'h70);
		ck(view.sp, 16'h00ff);
		ck(view.idx, 16'h55cd);
	endtask
	task automatic t_low;
		int n;
		op(OP_SEI, 8'h00, 16'h0000);
		op(OP_WAIT, 8'h00, 16'h0000);
		ck(view.condition_flags[3], 1'b0);
		@(posedge clock);
		ck(cpu_clk_run, 1'b0);
		irq_req <= 4'b0100;
		wt();
		irq_req <= 4'b0000;
		ck(view.pc, 16'h0908);
		op(OP_STOP, 8'h00, 16'h0000);
		ck(view.condition_flags[3], 1'b0);
		irq_req <= 4'b0100;
		n = 0;
		repeat (12) begin
			@(posedge clock);
			if (cpu_clk_run !== 1'b1)
				n++;
		end
		irq_req <= 4'b0000;
		ck(n >= STAB, 1'b1);
		wt();
		ck(view.pc, 16'h0908);
	endtask
	task automatic t_brk;
		instr_done <= 1'b0;
		break_req <= 1'b1;
		@(posedge clock);
		break_req <= 1'b0;
		repeat (3) @(posedge clock);
		ck(seq_ready, 1'b1);
		instr_done <= 1'b1;
		wt();
		ck(view.pc, 16'h0302);
		ck(instr_reg, SOFTWARE_INTERRUPT_INSTR);
		monitor_mode <= 1'b1;
		break_req <= 1'b1;
		@(posedge clock);
		break_req <= 1'b0;
		wt();
		ck(view.pc, 16'h0203);
		op(OP_SWI, 8'h00, 16'h0000);
		wt();
		ck(view.pc, 16'h0302);
	endtask
	// reset while asleep: the mask comes back set
	task automatic t_rerun;
		op(OP_WAIT, 8'h00, 16'h0000);
		ck(cpu_clk_run, 1'b0);
		arst_n <= 1'b0;
		@(posedge clock);
		arst_n <= 1'b1;
		wt();
		ck(view.condition_flags, 16'h0068);
		ck(view.sp, 16'h00ff);
		ck(view.pc, 16'h0100);
		ck(cpu_clk_run, 1'b1);
	endtask
	initial begin
		arst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		seq_cmd = '0;
		instr_done = 1'b1;
		irq_req = 4'h0;
		break_req = 1'b0;
		monitor_mode = 1'b0;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		t_reset();
		t_regs();
		t_stack();
		t_alu();
		t_irq();
		t_low();
		t_brk();
		t_rerun();
		give_verdict();
	end
	// the whole run needs well under a thousand cycles
	initial begin
		#50us;
		n_fail++;
		give_verdict();
	end
endmodule
